//--- rtl/pcact_pkg.sv
// Package: register map, field codes and timing constants of the positioner
package pcact_pkg;
    // ****************************************************************
    // Register map (word index on the plain register port)
    // ****************************************************************
    localparam logic [3:0] ADDR_SLOT = 4'h0;
    localparam logic [3:0] ADDR_RESTART = 4'h1;
    localparam logic [3:0] ADDR_LEGACY = 4'h2;
    localparam logic [3:0] ADDR_MASTER = 4'h3;
    localparam logic [3:0] ADDR_HTYPE = 4'h4;
    localparam logic [3:0] ADDR_HEDGE = 4'h5;
    localparam logic [3:0] ADDR_STYLE = 4'h6;
    localparam logic [3:0] ADDR_FILTER = 4'h7;
    localparam logic [3:0] ADDR_PTRIG = 4'h8;
    localparam logic [3:0] ADDR_SPEED = 4'h9;
    localparam logic [3:0] ADDR_ACCEL = 4'hA;
    localparam logic [3:0] ADDR_DECEL = 4'hB;
    localparam logic [3:0] ADDR_JERK = 4'hC;
    localparam logic [3:0] ADDR_STATUS = 4'hD;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // ****************************************************************
    // Field values
    // ****************************************************************
    localparam logic [1:0] SLOT_BUILTIN = 2'h0;
    localparam logic [2:0] MASTER_MAX = 3'h4;
    localparam logic HOME_WITH_MARK = 1'b0;
    localparam logic EDGE_RISING = 1'b0;
    localparam logic STYLE_EDGE = 1'b0;
    localparam int STATUS_W = 8;
    // ****************************************************************
    // Timing: filter counts in units of one millisecond
    // ****************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int FILTER_UNIT_US = 1000;
    localparam int FILTER_UNIT_CYC = CLK_HZ / 1_000_000 * FILTER_UNIT_US;
    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_SENSOR = 4'b0010,
        HS_MARK = 4'b0100,
        HS_DONE = 4'b1000
    } pcact_home_t;
endpackage

//--- rtl/pcact_cfg_if.sv
// Interface: register settings plus jog and search start controls passed from the top level to the sub-blocks
`timescale 1ns/1ps
interface pcact_cfg_if;
    logic [15:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] jerk;
    logic jog_on;
    logic search_start;
    logic search_type;
    logic sensor_edge;
    modport src (output speed, accel, decel, jerk, jog_on, search_start,
        search_type, sensor_edge);
    modport dst (input speed, accel, decel, jerk, jog_on, search_start,
        search_type, sensor_edge);
endinterface

//--- rtl/pcact_jog.sv
// Jog speed ramp with optional jerk limit on the acceleration
`timescale 1ns/1ps
module pcact_jog (
    input wire logic clk_i,
    input wire logic rstn_i,
    pcact_cfg_if.dst cfg,
    output logic signed [16:0] speed_o,
    output logic at_speed_o
);
    import pcact_pkg::*;

    logic signed [16:0] next_speed;
    logic [15:0] acc;
    logic [15:0] next_acc;
    logic signed [16:0] target;
    logic [15:0] limit;
    logic signed [17:0] diff;

    function automatic logic [15:0] min16(input logic [15:0] a,
        input logic [15:0] b);
        min16 = (a < b) ? a : b;
    endfunction

    always_comb begin
        target = cfg.jog_on ? $signed({1'b0, cfg.speed}) : 17'sh00000;
        diff = 18'(target) - 18'(speed_o);
        limit = (diff > 0) ? cfg.accel : cfg.decel;
        if (cfg.jerk == 16'h0000) begin
            next_acc = limit;
        end else begin
            next_acc = min16(limit, 16'(acc + cfg.jerk)); // [R3]
        end
        if (diff == 0) begin
            next_acc = 16'h0000;
        end
        // Ramp toward the target, holding once reached [R2]
        if (diff > $signed({2'b00, next_acc})) begin
            next_speed = 17'(speed_o + $signed({1'b0, next_acc}));
        end else if (-diff > $signed({2'b00, next_acc})) begin
            next_speed = 17'(speed_o - $signed({1'b0, next_acc}));
        end else begin
            next_speed = target;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            speed_o <= 17'sh00000;
            acc <= 16'h0000;
        end else begin
            speed_o <= next_speed;
            acc <= next_acc;
        end
    end

    assign at_speed_o = cfg.jog_on && (speed_o == $signed({1'b0, cfg.speed}));

    property p_jog_level;
        @(posedge clk_i) disable iff (!rstn_i)
        !cfg.jog_on && speed_o == 0 |=> speed_o == 0;
    endproperty
    a_jog_level: assert property (p_jog_level) // [R1]
        else $error("Jog moved while inactive");

    property p_jerk;
        @(posedge clk_i) disable iff (!rstn_i)
        cfg.jerk != 0 && acc < cfg.accel && acc < cfg.decel
        |=> acc <= 16'($past(acc) + cfg.jerk);
    endproperty
    a_jerk: assert property (p_jerk) // [R3]
        else $error("Jerk limit exceeded");
endmodule

//--- rtl/pcact_home.sv
// Machine zero search sequencer
`timescale 1ns/1ps
module pcact_home (
    input wire logic clk_i,
    input wire logic rstn_i,
    pcact_cfg_if.dst cfg,
    input wire logic sensor_i,
    input wire logic mark_i,
    output logic moving_o,
    output logic done_o
);
    import pcact_pkg::*;

    pcact_home_t state;
    pcact_home_t next_state;
    logic sensor_q;
    logic hit;

    // Active sensor edge chosen by software [R10]
    assign hit = (cfg.sensor_edge == EDGE_RISING) ? (sensor_i && !sensor_q)
                                                  : (!sensor_i && sensor_q);

    always_comb begin
        case (state)
            HS_IDLE: begin
                next_state = cfg.search_start ? HS_SENSOR : HS_IDLE;
            end
            HS_SENSOR: begin
                if (hit) begin
                    next_state = (cfg.search_type == HOME_WITH_MARK) ?
                        HS_MARK : HS_DONE; // [R8] [R9]
                end else begin
                    next_state = HS_SENSOR;
                end
            end
            HS_MARK: begin
                next_state = mark_i ? HS_DONE : HS_MARK; // [R8]
            end
            HS_DONE: begin
                next_state = cfg.search_start ? HS_SENSOR : HS_DONE;
            end
            default: begin
                next_state = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= HS_IDLE;
            sensor_q <= 1'b0;
        end else begin
            state <= next_state;
            sensor_q <= sensor_i;
        end
    end

    assign moving_o = (state == HS_SENSOR) || (state == HS_MARK);
    assign done_o = (state == HS_DONE);

    property p_sensor_only;
        @(posedge clk_i) disable iff (!rstn_i)
        state == HS_SENSOR && hit && cfg.search_type != HOME_WITH_MARK
        |=> state == HS_DONE;
    endproperty
    a_sensor_only: assert property (p_sensor_only) // [R9]
        else $error("Sensor-only search did not stop");

    property p_with_mark;
        @(posedge clk_i) disable iff (!rstn_i)
        state == HS_SENSOR && hit && cfg.search_type == HOME_WITH_MARK
        |=> state == HS_MARK ##0 moving_o;
    endproperty
    a_with_mark: assert property (p_with_mark) // [R8]
        else $error("Search stopped before the zero mark");

    property p_edge;
        @(posedge clk_i) disable iff (!rstn_i)
        hit |-> sensor_i == (cfg.sensor_edge == EDGE_RISING);
    endproperty
    a_edge: assert property (p_edge) // [R10]
        else $error("Sensor taken on wrong edge");
endmodule

//--- rtl/pcact_top.sv
// Positioner cycle activation: registers, trigger path, jog and home search
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// Summary of operation
// R1: Jog runs only while its input or parameter trigger is high.
// R2: Jog ramps with accel or decel to programmed speed, then holds it.
// R3: Nonzero jerk limits how fast jog acceleration may change.
// R4: Slot 0 picks built-in inputs; slots 1 to 3 pick accessory inputs.
// R5: A 0 to 1 write of restart returns every cycle to its first motion.
// R6: Legacy switch at 1 selects legacy references; needs serial mode.
// R7: Follow master source 0 to 4: none, fast, network, encoder 1, 2.
// R8: Search type 0 stops only after the feedback zero mark.
// R9: Search type 1 stops at the home sensor position.
// R10: Home sensor taken on rising edge for 0, falling for 1.
// R11: Trigger style 0 starts a cycle on a rising trigger edge.
// R12: Trigger style 1 re-activates the cycle while the trigger is high.
// R13: In edge mode the controller returns a trigger low after its edge; here parameter_cycle_trigger stays set until software writes 0.
// R14: A trigger counts only after staying high beyond the filter time.
module pcact_top (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic [2:0] builtin_in_i,
    input wire logic [2:0] slot1_in_i,
    input wire logic [2:0] slot2_in_i,
    input wire logic [2:0] slot3_in_i,
    input wire logic [1:0] input_sel_i,
    input wire logic jog_mode_i,
    input wire logic home_start_i,
    input wire logic home_sensor_i,
    input wire logic zero_mark_i,
    input wire logic [15:0] native_ref_i,
    input wire logic [15:0] legacy_ref_i,
    output logic [15:0] ref_o,
    output logic [2:0] master_sel_o,
    output logic cycle_start_o,
    output logic cycle_rewind_o,
    output logic signed [16:0] jog_speed_o,
    output logic home_moving_o,
    output logic home_done_o
);
    import pcact_pkg::*;

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [1:0] trigger_slot_select;
    logic cycle_restart_control;
    logic legacy_reference_map;
    logic [2:0] follow_master_source;
    logic home_search_type;
    logic home_sensor_edge;
    logic cycle_trigger_style;
    logic [15:0] cycle_activation_filter;
    logic parameter_cycle_trigger;
    logic [15:0] profile_target_speed;
    logic [15:0] profile_acceleration;
    logic [15:0] profile_deceleration;
    logic [15:0] profile_jerk_limit;
    logic [1:0] next_slot;
    logic next_restart;
    logic next_legacy;
    logic [2:0] next_master;
    logic next_htype;
    logic next_hedge;
    logic next_style;
    logic [15:0] next_filter;
    logic next_ptrig;
    logic [15:0] next_speed;
    logic [15:0] next_accel;
    logic [15:0] next_decel;
    logic [15:0] next_jerk;
    logic [15:0] next_rdata;
    logic [STATUS_W-1:0] status;
    logic at_speed;

    function automatic logic wr_hit(input logic [3:0] a);
        wr_hit = wr_i && (addr_i == a);
    endfunction

    always_comb begin
        next_slot = wr_hit(ADDR_SLOT) ? wdata_i[1:0] : trigger_slot_select;
        next_restart = wr_hit(ADDR_RESTART) ? wdata_i[0]
                                            : cycle_restart_control;
        next_legacy = wr_hit(ADDR_LEGACY) ? wdata_i[0] : legacy_reference_map;
        next_master = follow_master_source;
        // Whole word is range checked so out-of-range codes never alias
        if (wr_hit(ADDR_MASTER) && wdata_i <= 16'(MASTER_MAX)) begin
            next_master = wdata_i[2:0]; // [R7]
        end
        next_htype = wr_hit(ADDR_HTYPE) ? wdata_i[0] : home_search_type;
        next_hedge = wr_hit(ADDR_HEDGE) ? wdata_i[0] : home_sensor_edge;
        next_style = wr_hit(ADDR_STYLE) ? wdata_i[0] : cycle_trigger_style;
        next_filter = wr_hit(ADDR_FILTER) ? wdata_i : cycle_activation_filter;
        next_ptrig = wr_hit(ADDR_PTRIG) ? wdata_i[0] : parameter_cycle_trigger;
        next_speed = wr_hit(ADDR_SPEED) ? wdata_i : profile_target_speed;
        next_accel = wr_hit(ADDR_ACCEL) ? wdata_i : profile_acceleration;
        next_decel = wr_hit(ADDR_DECEL) ? wdata_i : profile_deceleration;
        next_jerk = wr_hit(ADDR_JERK) ? wdata_i : profile_jerk_limit;
        next_rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                ADDR_SLOT: next_rdata = {14'h0000, trigger_slot_select};
                ADDR_RESTART: next_rdata = {15'h0000, cycle_restart_control};
                ADDR_LEGACY: next_rdata = {15'h0000, legacy_reference_map};
                ADDR_MASTER: next_rdata = {13'h0000, follow_master_source};
                ADDR_HTYPE: next_rdata = {15'h0000, home_search_type};
                ADDR_HEDGE: next_rdata = {15'h0000, home_sensor_edge};
                ADDR_STYLE: next_rdata = {15'h0000, cycle_trigger_style};
                ADDR_FILTER: next_rdata = cycle_activation_filter;
                ADDR_PTRIG: next_rdata = {15'h0000, parameter_cycle_trigger};
                ADDR_SPEED: next_rdata = profile_target_speed;
                ADDR_ACCEL: next_rdata = profile_acceleration;
                ADDR_DECEL: next_rdata = profile_deceleration;
                ADDR_JERK: next_rdata = profile_jerk_limit;
                ADDR_STATUS: next_rdata = {8'h00, status};
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trigger_slot_select <= REG_RESET[1:0];
            cycle_restart_control <= REG_RESET[0];
            legacy_reference_map <= REG_RESET[0];
            follow_master_source <= REG_RESET[2:0];
            home_search_type <= REG_RESET[0];
            home_sensor_edge <= REG_RESET[0];
            cycle_trigger_style <= REG_RESET[0];
            cycle_activation_filter <= REG_RESET;
            parameter_cycle_trigger <= REG_RESET[0];
            profile_target_speed <= REG_RESET;
            profile_acceleration <= REG_RESET;
            profile_deceleration <= REG_RESET;
            profile_jerk_limit <= REG_RESET;
            rdata_o <= REG_RESET;
        end else begin
            trigger_slot_select <= next_slot;
            cycle_restart_control <= next_restart;
            legacy_reference_map <= next_legacy;
            follow_master_source <= next_master;
            home_search_type <= next_htype;
            home_sensor_edge <= next_hedge;
            cycle_trigger_style <= next_style;
            cycle_activation_filter <= next_filter;
            parameter_cycle_trigger <= next_ptrig;
            profile_target_speed <= next_speed;
            profile_acceleration <= next_accel;
            profile_deceleration <= next_decel;
            profile_jerk_limit <= next_jerk;
            rdata_o <= next_rdata;
        end
    end

    // ****************************************************************
    // Trigger source, filter and activation style
    // ****************************************************************
    logic [2:0] slot_bus;
    logic raw_trig;
    logic [31:0] filt_cnt;
    logic [31:0] next_filt_cnt;
    logic [31:0] filt_limit;
    logic trig_ok;
    logic trig_ok_q;
    logic restart_q;
    logic next_start;
    logic next_rewind;

    always_comb begin
        case (trigger_slot_select) // [R4]
            SLOT_BUILTIN: slot_bus = builtin_in_i;
            2'h1: slot_bus = slot1_in_i;
            2'h2: slot_bus = slot2_in_i;
            2'h3: slot_bus = slot3_in_i;
            default: slot_bus = builtin_in_i;
        endcase
        raw_trig = parameter_cycle_trigger;
        if (input_sel_i != 2'h0) begin
            raw_trig = raw_trig || slot_bus[input_sel_i - 2'h1];
        end
        filt_limit = 32'(cycle_activation_filter) * 32'(FILTER_UNIT_CYC);
        // Count must pass the limit, not just reach it [R14]
        if (!raw_trig) begin
            next_filt_cnt = 32'h0000_0000;
        end else if (filt_cnt <= filt_limit) begin
            next_filt_cnt = filt_cnt + 32'h0000_0001;
        end else begin
            next_filt_cnt = filt_cnt;
        end
        trig_ok = raw_trig && (filt_cnt > filt_limit); // [R14]
        // Edge style needs the trigger to fall again first [R11] [R13]
        if (cycle_trigger_style == STYLE_EDGE) begin
            next_start = !jog_mode_i && trig_ok && !trig_ok_q;
        end else begin
            next_start = !jog_mode_i && trig_ok; // [R12]
        end
        next_rewind = cycle_restart_control && !restart_q; // [R5]
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            filt_cnt <= 32'h0000_0000;
            trig_ok_q <= 1'b0;
            restart_q <= 1'b0;
            cycle_start_o <= 1'b0;
            cycle_rewind_o <= 1'b0;
        end else begin
            filt_cnt <= next_filt_cnt;
            trig_ok_q <= trig_ok;
            restart_q <= cycle_restart_control;
            cycle_start_o <= next_start;
            cycle_rewind_o <= next_rewind;
        end
    end

    // ****************************************************************
    // References, master, jog and home search
    // ****************************************************************
    // Legacy map is only meaningful with serial-written references [R6]
    assign ref_o = legacy_reference_map ? legacy_ref_i : native_ref_i;
    assign master_sel_o = follow_master_source; // [R7]
    assign status = {2'b00, home_moving_o, home_done_o, at_speed,
        trig_ok, cycle_trigger_style, legacy_reference_map};

    pcact_cfg_if cfg ();
    assign cfg.speed = profile_target_speed;
    assign cfg.accel = profile_acceleration;
    assign cfg.decel = profile_deceleration;
    assign cfg.jerk = profile_jerk_limit;
    assign cfg.jog_on = jog_mode_i && raw_trig; // [R1]
    assign cfg.search_start = home_start_i;
    assign cfg.search_type = home_search_type;
    assign cfg.sensor_edge = home_sensor_edge;

    pcact_jog u_jog (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .cfg(cfg),
        .speed_o(jog_speed_o),
        .at_speed_o(at_speed)
    );

    pcact_home u_home (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .cfg(cfg),
        .sensor_i(home_sensor_i),
        .mark_i(zero_mark_i),
        .moving_o(home_moving_o),
        .done_o(home_done_o)
    );

    property p_rewind;
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(cycle_restart_control) |=> cycle_rewind_o ##1 !cycle_rewind_o;
    endproperty
    a_rewind: assert property (p_rewind) // [R5]
        else $error("Restart edge not turned into one rewind pulse");

    property p_edge_style;
        @(posedge clk_i) disable iff (!rstn_i)
        cycle_trigger_style == STYLE_EDGE && cycle_start_o |=> !cycle_start_o;
    endproperty
    a_edge_style: assert property (p_edge_style) // [R11]
        else $error("Edge style started twice in a row");

    property p_level_style;
        @(posedge clk_i) disable iff (!rstn_i)
        cycle_trigger_style != STYLE_EDGE && trig_ok && !jog_mode_i
        |=> cycle_start_o;
    endproperty
    a_level_style: assert property (p_level_style) // [R12]
        else $error("Level style did not keep activating");

    property p_filter;
        @(posedge clk_i) disable iff (!rstn_i)
        !raw_trig ##1 raw_trig |-> !trig_ok;
    endproperty
    a_filter: assert property (p_filter) // [R14]
        else $error("Trigger taken before filter time");

    property p_slot;
        @(posedge clk_i) disable iff (!rstn_i)
        trigger_slot_select == 2'h0 |-> slot_bus == builtin_in_i;
    endproperty
    a_slot: assert property (p_slot) // [R4]
        else $error("Built-in inputs not selected for slot 0");

    property p_legacy;
        @(posedge clk_i) disable iff (!rstn_i)
        legacy_reference_map |-> ref_o == legacy_ref_i;
    endproperty
    a_legacy: assert property (p_legacy) // [R6]
        else $error("Legacy reference map ignored");

    property p_jog_gate;
        @(posedge clk_i) disable iff (!rstn_i)
        jog_mode_i |=> !cycle_start_o;
    endproperty
    a_jog_gate: assert property (p_jog_gate) // [R1]
        else $error("Cycle started while jog owns the trigger");
endmodule

//--- verification/pcact_partner.sv
// Far-side model: digital trigger inputs of the drive and its slots
`timescale 1ns/1ps
module pcact_partner (
    input wire logic clk_i,
    input wire logic [1:0] slot_i,
    input wire logic [1:0] sel_i,
    input wire logic trig_i,
    output logic [2:0] builtin_o,
    output logic [2:0] slot1_o,
    output logic [2:0] slot2_o,
    output logic [2:0] slot3_o
);
    // ********************
    // Input levels
    // ********************
    logic [2:0] noise = 3'h5;
    logic [2:0] lvl;
    // Idle slots toggle every cycle so a wrong slot choice shows up
    always @(posedge clk_i) begin
        noise <= ~noise;
    end
    // Trigger goes back low as soon as the bench drops it
    assign lvl = trig_i ? 3'h1 << (sel_i - 2'h1) : 3'h0;
    assign builtin_o = (slot_i == 2'h0) ? lvl : noise;
    assign slot1_o = (slot_i == 2'h1) ? lvl : noise;
    assign slot2_o = (slot_i == 2'h2) ? lvl : noise;
    assign slot3_o = (slot_i == 2'h3) ? lvl : noise;
endmodule

//--- verification/tb_positioner_cycle_activation.sv
// Self-checking bench for the positioner cycle activation block
`timescale 1ns/1ps
module tb_positioner_cycle_activation;
    import pcact_pkg::*;
    // ********************
    // Bench
    // ********************
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic jog_i = 1'b0;
    logic hstart = 1'b0;
    logic hsens = 1'b0;
    logic hmark = 1'b0;
    logic [1:0] slot = 2'h0;
    logic [1:0] sel = 2'h1;
    logic trig = 1'b0;
    logic [2:0] b_in, s1_in, s2_in, s3_in, msel;
    logic [15:0] rdata_o, ref_o;
    logic start_o, rew_o, moving_o, done_o;
    logic signed [16:0] speed_o;
    int fail_count = 0;
    int checked = 0;
    int starts = 0;
    int rews = 0;
    int cyc = 0;
    int s0;
    pcact_partner u_far (.clk_i(clk_i), .slot_i(slot), .sel_i(sel),
        .trig_i(trig), .builtin_o(b_in), .slot1_o(s1_in),
        .slot2_o(s2_in), .slot3_o(s3_in));
    pcact_top u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .builtin_in_i(b_in), .slot1_in_i(s1_in), .slot2_in_i(s2_in),
        .slot3_in_i(s3_in), .input_sel_i(sel), .jog_mode_i(jog_i),
        .home_start_i(hstart), .home_sensor_i(hsens),
        .zero_mark_i(hmark), .native_ref_i(16'h1234),
        .legacy_ref_i(16'hABCD), .ref_o(ref_o), .master_sel_o(msel),
        .cycle_start_o(start_o), .cycle_rewind_o(rew_o),
        .jog_speed_o(speed_o), .home_moving_o(moving_o),
        .home_done_o(done_o));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // Counted mid-cycle so no launching edge races the count
    always @(negedge clk_i) begin
        cyc++;
        starts += (start_o === 1'b1);
        rews += (rew_o === 1'b1);
        if (cyc == 60000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (fail_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [16:0] e,
        input logic [16:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        cy(1);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        cy(1);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        cy(1);
        addr_i <= a;
        rd_i <= 1'b1;
        cy(1);
        rd_i <= 1'b0;
        #1 chk("rdata", 17'(e), 17'(rdata_o));
    endtask
    task automatic trun(input int hi, input int e, input string n);
        s0 = starts;
        trig <= 1'b1;
        cy(hi);
        trig <= 1'b0;
        cy(6);
        chk(n, 17'(e), 17'(starts - s0));
    endtask
    task automatic hgo();
        cy(1);
        hstart <= 1'b1;
        cy(1);
        hstart <= 1'b0;
        cy(2);
        #1 chk("home_moving", 17'h1, 17'(moving_o));
    endtask
    task automatic hstep(input logic s, input logic m, input logic e,
        input string n);
        cy(1);
        hsens <= s;
        hmark <= m;
        cy(1);
        hmark <= 1'b0;
        cy(4);
        #1 chk(n, 17'(e), 17'(done_o));
    endtask
    initial begin
        cy(5);
        rstn_i <= 1'b1;
        for (int a = 0; a < 9; a++) begin
            rd(4'(a), REG_RESET);
        end
        rd(4'hE, 16'h0000);
        for (int m = 0; m < 6; m++) begin
            wr(ADDR_MASTER, 16'(m));
            rd(ADDR_MASTER, 16'(m > 4 ? 4 : m));
            chk("master", 17'(m > 4 ? 4 : m), 17'(msel));
        end
        wr(ADDR_LEGACY, 16'h0001);
        rd(ADDR_LEGACY, 16'h0001);
        chk("ref_legacy", 17'hABCD, 17'(ref_o));
        wr(ADDR_LEGACY, 16'h0000);
        rd(ADDR_LEGACY, 16'h0000);
        chk("ref_native", 17'h1234, 17'(ref_o));
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_SLOT, 16'(s));
            slot <= 2'(s);
            sel <= 2'(s % 3 + 1);
            cy(6);
            trun(3, 1, "edge_start");
        end
        trun(20, 1, "edge_held");
        s0 = starts;
        wr(ADDR_PTRIG, 16'h0001);
        cy(10);
        wr(ADDR_PTRIG, 16'h0000);
        cy(6);
        chk("param_start", 17'h1, 17'(starts - s0));
        wr(ADDR_STYLE, 16'h0001);
        trun(10, 9, "level_start");
        wr(ADDR_STYLE, 16'h0000);
        wr(ADDR_FILTER, 16'h0001);
        trun(9000, 0, "filter_short");
        trun(10010, 1, "filter_long");
        wr(ADDR_FILTER, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            s0 = rews;
            wr(ADDR_RESTART, 16'(i != 2));
            cy(4);
            chk("rewind", 17'(i == 0 || i == 3), 17'(rews - s0));
        end
        wr(ADDR_SPEED, 16'h0064);
        wr(ADDR_ACCEL, 16'h000A);
        wr(ADDR_DECEL, 16'h000A);
        jog_i <= 1'b1;
        s0 = starts;
        trig <= 1'b1;
        cy(6);
        #1 chk("ramp", 17'h1, 17'(speed_o >= 30 && speed_o < 100));
        cy(30);
        #1 chk("jog_speed", 17'h64, 17'(speed_o));
        rd(ADDR_STATUS, 16'h000C);
        cy(1);
        trig <= 1'b0;
        cy(30);
        #1 chk("jog_stop", 17'h0, 17'(speed_o));
        chk("jog_no_cycle", 17'h0, 17'(starts - s0));
        wr(ADDR_JERK, 16'h0001);
        trig <= 1'b1;
        cy(6);
        #1 chk("jerk_ramp", 17'h1, 17'(speed_o < 30));
        cy(60);
        #1 chk("jerk_speed", 17'h64, 17'(speed_o));
        cy(1);
        trig <= 1'b0;
        cy(80);
        jog_i <= 1'b0;
        wr(ADDR_HTYPE, 16'h0001);
        hgo();
        hstep(1'b1, 1'b0, 1'b1, "sensor_stop");
        wr(ADDR_HTYPE, 16'h0000);
        hgo();
        hstep(1'b0, 1'b0, 1'b0, "fall_ignored");
        hstep(1'b1, 1'b0, 1'b0, "wait_mark");
        chk("still_moving", 17'h1, 17'(moving_o));
        hstep(1'b1, 1'b1, 1'b1, "mark_stop");
        wr(ADDR_HTYPE, 16'h0001);
        wr(ADDR_HEDGE, 16'h0001);
        hgo();
        hstep(1'b0, 1'b0, 1'b1, "fall_stop");
        print_verdict();
    end
endmodule
